// file: mic_power_control.sv
/*
 * Power-state control and serial data slot for a microphone acting as a
 * serial-audio slave: classifies the incoming bit clock, holds the data
 * pin released in sleep, and shifts samples out in its own channel slot.
 * Assumes bit clock, word select and channel select arrive as raw pins,
 * and samples come from logic on mclk through a valid/ready stream.
 */
`timescale 1ns/100ps

// Summary of operation
// - A bit clock between 600 and 800 kHz puts the block in low-rate mode.
// - A bit clock below 200 kHz puts the block in sleep.
// - In sleep the data pin is released and driven to no level.
// - Output starts 6 ms after a valid clock returns from sleep.
// - A sleeping block shares the data line without loading it.
// - Words are MSB first, one clock late, 24 bits with 4 zero LSBs or 16.
// - The pin is driven only in the own slot, released right after LSB.
// - Channel select picks the slot after the word-select fall or rise.
module mic_power_control #(
   parameter int WAKE_CYCLES = mic_power_pkg::WAKE_CYC,
   parameter int FIFO_DEPTH  = mic_power_pkg::FIFO_DEPTH
) (
   input  wire logic                        mclk,
   input  wire logic                        resetn,
   input  wire logic                        clkEn,
   input  wire logic                        bitClk,
   input  wire logic                        wordSel,
   input  wire logic                        channelSlotSelect,
   input  wire logic [mic_power_pkg::SAMPLE_BITS-1:0] sampleData,
   input  wire logic                        sampleValid,
   output logic                             sampleReady,
   output logic                             sdOut,
   output logic                             sdOe,
   output mic_power_pkg::power_state_t      powerState
);

   localparam int PW = mic_power_pkg::PERIOD_W;
   localparam int SW = mic_power_pkg::SAMPLE_BITS;
   localparam int CW = mic_power_pkg::BITCNT_W;
   localparam int WW = $clog2(WAKE_CYCLES + 1);
   localparam logic [PW-1:0] SLEEP_LIM = PW'(mic_power_pkg::SLEEP_CYC);
   localparam logic [PW-1:0] LOW_MIN   = PW'(mic_power_pkg::LOW_MIN_CYC);
   localparam logic [PW-1:0] LOW_MAX   = PW'(mic_power_pkg::LOW_MAX_CYC);
   localparam logic [PW-1:0] FULL_MIN  = PW'(mic_power_pkg::FULL_MIN_CYC);
   localparam logic [PW-1:0] FULL_MAX  = PW'(mic_power_pkg::FULL_MAX_CYC);
   localparam logic [PW-1:0] PERIOD_ONE = PW'(1);
   localparam logic [WW-1:0] WAKE_LIM  = WW'(WAKE_CYCLES);
   localparam logic [CW-1:0] LEN_FULL  =
      CW'(mic_power_pkg::WORD_FULL_BITS - 1);
   localparam logic [CW-1:0] LEN_LOW   =
      CW'(mic_power_pkg::WORD_LOW_BITS - 1);
   localparam logic [CW-1:0] PAD_LIM   = CW'(mic_power_pkg::PAD_BITS);
   localparam int PAD  = mic_power_pkg::PAD_BITS;
   localparam int LPAD = SW - mic_power_pkg::WORD_LOW_BITS;
   localparam int NP   = mic_power_pkg::PIN_NUM;

   logic [NP-1:0] pinS1_q;
   logic [NP-1:0] pinS2_q;
   logic [NP-1:0] pinS3_q;
   logic [NP-1:0] pinF_q;
   logic          sckPrev_q;
   logic          sckRise;
   logic          sckFall;
   logic          wsF;
   logic          chanF;
   logic [PW-1:0] periodCnt_q;
   logic          inLow;
   logic          inFull;
   logic [WW-1:0] wakeCnt_q;
   logic          awake;
   logic          wsSmp_q;
   logic          startPend_q;
   logic [SW-1:0] shift_q;
   logic [CW-1:0] bitCnt_q;
   logic [SW-1:0] word;
   logic [CW-1:0] wordLen;
   logic [SW-1:0] fifoData;
   logic          fifoValid;
   logic          fifoPop;

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   // three stages; a level is taken only once stages two and three agree,
   // which also swallows single-cycle glitches on the pins
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pinS1_q   <= '0;
         pinS2_q   <= '0;
         pinS3_q   <= '0;
         pinF_q    <= '0;
         sckPrev_q <= 1'b0;
      end else if (clkEn) begin
         pinS1_q   <= {channelSlotSelect, wordSel, bitClk};
         pinS2_q   <= pinS1_q;
         pinS3_q   <= pinS2_q;
         for (int i = 0; i < NP; i++) begin
            if (pinS2_q[i] == pinS3_q[i]) begin
               pinF_q[i] <= pinS3_q[i];
            end
         end
         sckPrev_q <= pinF_q[mic_power_pkg::PIN_SCK];
      end
   end

   assign sckRise = pinF_q[mic_power_pkg::PIN_SCK] & ~sckPrev_q;
   assign sckFall = ~pinF_q[mic_power_pkg::PIN_SCK] & sckPrev_q;
   assign wsF     = pinF_q[mic_power_pkg::PIN_WS];
   assign chanF   = pinF_q[mic_power_pkg::PIN_CHAN];

   // ------------------------------------------------------------------
   // bit-clock rate classification
   // ------------------------------------------------------------------
   // period in reference cycles, saturating at the sleep limit so a
   // stopped clock reads the same as a very slow one
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         periodCnt_q <= SLEEP_LIM;
      end else if (clkEn) begin
         if (sckRise) begin
            periodCnt_q <= PERIOD_ONE;
         end else if (periodCnt_q != SLEEP_LIM) begin
            periodCnt_q <= periodCnt_q + 1'b1;
         end
      end
   end

   assign inLow  = (periodCnt_q >= LOW_MIN) & (periodCnt_q <= LOW_MAX);
   assign inFull = (periodCnt_q >= FULL_MIN) & (periodCnt_q <= FULL_MAX);

   // state from measured band
   // a single period decides; sampling jitter is one cycle, well inside
   // the gaps between bands
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         powerState <= mic_power_pkg::PWR_SLEEP;
      end else if (clkEn) begin
         if (periodCnt_q == SLEEP_LIM) begin
            powerState <= mic_power_pkg::PWR_SLEEP;
         end else if (sckRise && inLow) begin
            powerState <= mic_power_pkg::PWR_LOW;
         end else if (sckRise && inFull) begin
            powerState <= mic_power_pkg::PWR_FULL;
         end
      end
   end

   // wake-up delay counter
   // only a pass through sleep restarts it; low/full switching does not
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wakeCnt_q <= '0;
      end else if (clkEn) begin
         if (powerState == mic_power_pkg::PWR_SLEEP) begin
            wakeCnt_q <= '0;
         end else if (wakeCnt_q != WAKE_LIM) begin
            wakeCnt_q <= wakeCnt_q + 1'b1;
         end
      end
   end

   assign awake = (wakeCnt_q == WAKE_LIM) &
                  (powerState != mic_power_pkg::PWR_SLEEP);

   // ------------------------------------------------------------------
   // serial slot
   // ------------------------------------------------------------------
   // word select as seen at each rising bit-clock edge
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wsSmp_q <= 1'b0;
      end else if (clkEn && sckRise) begin
         wsSmp_q <= wsF;
      end
   end

   // word build per mode
   // an empty FIFO sends silence rather than stalling the frame
   always_comb begin
      word    = '0;
      wordLen = LEN_LOW;
      unique case (powerState)
         mic_power_pkg::PWR_FULL: begin
            word    = {fifoData[SW-1:PAD], {PAD{1'b0}}};
            wordLen = LEN_FULL;
         end
         mic_power_pkg::PWR_LOW: begin
            word    = {fifoData[SW-1:LPAD], {LPAD{1'b0}}};
            wordLen = LEN_LOW;
         end
         default: begin
            word    = '0;
            wordLen = LEN_LOW;
         end
      endcase
      if (!fifoValid) begin
         word = '0;
      end
   end

   assign fifoPop = clkEn & awake & sckFall & startPend_q;

   // pin drive and shifter
   // data changes on falling edges so the master samples on rising ones
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         startPend_q <= 1'b0;
         shift_q     <= '0;
         bitCnt_q    <= '0;
         sdOut       <= 1'b0;
         sdOe        <= 1'b0;
      end else if (clkEn) begin
         if (!awake) begin
            startPend_q <= 1'b0;
            bitCnt_q    <= '0;
            sdOut       <= 1'b0;
            sdOe        <= 1'b0;
         end else if (sckRise) begin
            startPend_q <= (wsF != wsSmp_q) & (wsF == chanF);
         end else if (sckFall) begin
            if (startPend_q) begin
               sdOut       <= word[SW-1];
               shift_q     <= {word[SW-2:0], 1'b0};
               bitCnt_q    <= wordLen;
               sdOe        <= 1'b1;
               startPend_q <= 1'b0;
            end else if (sdOe && bitCnt_q != '0) begin
               sdOut    <= shift_q[SW-1];
               shift_q  <= {shift_q[SW-2:0], 1'b0};
               bitCnt_q <= bitCnt_q - 1'b1;
            end else begin
               sdOut <= 1'b0;
               sdOe  <= 1'b0;   // released straight after the LSB
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // sample buffer
   // ------------------------------------------------------------------
   mic_sample_fifo #(
      .WIDTH (SW),
      .DEPTH (FIFO_DEPTH)
   ) sampleFifo (
      .mclk     (mclk),
      .resetn   (resetn),
      .clkEn    (clkEn),
      .inData   (sampleData),
      .inValid  (sampleValid),
      .inReady  (sampleReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (fifoPop)
   );

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_low_band_entry: assert property (
      @(posedge mclk) disable iff (!resetn)
      (clkEn && sckRise && inLow) |=>
         powerState == mic_power_pkg::PWR_LOW)
      else $error("low band period did not select low-rate mode");

   a_slow_clock_sleep: assert property (
      @(posedge mclk) disable iff (!resetn)
      (clkEn && periodCnt_q == SLEEP_LIM) |=>
         powerState == mic_power_pkg::PWR_SLEEP)
      else $error("slow bit clock did not enter sleep");

   a_sleep_released: assert property (
      @(posedge mclk) disable iff (!resetn)
      (clkEn && powerState == mic_power_pkg::PWR_SLEEP) |=> !sdOe)
      else $error("data pin driven while asleep");

   a_wake_delay_met: assert property (
      @(posedge mclk) disable iff (!resetn)
      $rose(sdOe) |-> (wakeCnt_q == WAKE_LIM) &&
         $past(powerState) != mic_power_pkg::PWR_SLEEP)
      else $error("data driven before wake delay elapsed");

   a_sleep_no_load: assert property (
      @(posedge mclk) disable iff (!resetn)
      (clkEn && powerState == mic_power_pkg::PWR_SLEEP) |=> !sdOe && !sdOut)
      else $error("sleeping block still loads the data line");

   a_pad_bits_zero: assert property (
      @(posedge mclk) disable iff (!resetn)
      (sdOe && powerState == mic_power_pkg::PWR_FULL &&
       bitCnt_q < PAD_LIM) |-> !sdOut)
      else $error("full-rate pad bit not zero");

   a_release_after_lsb: assert property (
      @(posedge mclk) disable iff (!resetn)
      (clkEn && sckFall && sdOe && bitCnt_q == '0 && !startPend_q) |=>
         !sdOe)
      else $error("data pin not released after the LSB");

   a_slot_select: assert property (
      @(posedge mclk) disable iff (!resetn)
      $rose(sdOe) |-> wsSmp_q == chanF)
      else $error("word driven in the wrong channel slot");

   a_gap_holds: assert property (
      @(posedge mclk) disable iff (!resetn)
      (clkEn && sckRise && !inLow && !inFull &&
       periodCnt_q != SLEEP_LIM) |=> $stable(powerState))
      else $error("gap frequency changed the power state");

endmodule

// file: mic_power_control_tb.sv
/*
 * Self-checking bench for the microphone power-state control.
 * Assumes the serial bus host model and a shortened wake count; the
 * host samples the data pin on its own bit clock rising edge.
 */
`timescale 1ns/100ps

module mic_power_control_tb;
   localparam int WAKE      = 1200; // outlasts the first right slot
   localparam int DEPTH     = mic_power_pkg::FIFO_DEPTH;
   localparam int FULL_HALF = 163; // about 3.07 MHz
   localparam int LOW_HALF  = 650; // about 769 kHz

   logic                        mclk;
   logic                        resetn;
   logic                        clkEn;
   logic                        channelSlotSelect;
   logic [23:0]                 sampleData;
   logic                        sampleValid;
   logic                        sampleReady;
   logic                        sdOut;
   logic                        sdOe;
   mic_power_pkg::power_state_t powerState;
   logic                        busRun;
   int                          halfNs;
   int                          frameBits;
   logic                        bitClk;
   logic                        wordSel;
   int                          mismatches;
   int                          checkCount;
   logic [23:0]                 pushed [$];

   // ----------------------------------------------------------------
   // clock, design and far side
   // ----------------------------------------------------------------
   // 50 MHz reference
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   mic_power_control #(.WAKE_CYCLES(WAKE), .FIFO_DEPTH(DEPTH)) dut (
      .mclk(mclk), .resetn(resetn), .clkEn(clkEn), .bitClk(bitClk),
      .wordSel(wordSel), .channelSlotSelect(channelSlotSelect),
      .sampleData(sampleData), .sampleValid(sampleValid),
      .sampleReady(sampleReady), .sdOut(sdOut), .sdOe(sdOe),
      .powerState(powerState));

   serial_bus_host host (.busRun(busRun), .halfNs(halfNs),
      .frameBits(frameBits), .bitClk(bitClk), .wordSel(wordSel));

   // ----------------------------------------------------------------
   // comparisons and bounded waits
   // ----------------------------------------------------------------
   task automatic tallyAndFinish;
      $display("checks %0d mismatches %0d", checkCount, mismatches);
      if (mismatches == 0 && checkCount > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic checkWord(input string what, input logic [23:0] exp,
                            input logic [23:0] got);
      checkCount++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic checkFlag(input string what, input logic exp,
                            input logic got);
      checkCount++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask

   // polled on the falling mclk edge so design outputs have settled
   task automatic waitState(input mic_power_pkg::power_state_t s,
                            input int bound);
      checkCount++;
      for (int i = 0; i < bound; i++) begin
         @(negedge mclk);
         if (powerState === s) return;
      end
      mismatches++;
      $display("unexpected powerState: expected %0d seen %0d", s, powerState);
      tallyAndFinish;
   endtask

   task automatic waitRise;
      logic p;
      p = bitClk;
      for (int i = 0; i < 4000; i++) begin
         @(negedge mclk);
         if (bitClk && !p) return;
         p = bitClk;
      end
      mismatches++;
      $display("unexpected bitClk: expected rise seen none");
      tallyAndFinish;
   endtask

   // one word of the given slot as the host sees it
   task automatic captureWord(input logic ch, input int n,
                              output logic [23:0] w);
      logic p;
      int   i;
      w = 24'h000000;
      p = wordSel;
      for (i = 0; i < 20000; i++) begin
         @(negedge mclk);
         if (wordSel === ch && p !== ch) break;
         p = wordSel;
      end
      if (i == 20000) begin
         mismatches++;
         $display("unexpected wordSel: expected edge seen none");
         tallyAndFinish;
      end
      waitRise; // the msb waits one bit clock after the slot opens
      for (int b = 0; b < n; b++) begin
         waitRise;
         checkFlag("drive in slot", 1'b1, sdOe);
         w[23-b] = sdOut;
      end
      waitRise;
      checkFlag("release after lsb", 1'b0, sdOe);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic fillWhileAsleep;
      int refused;
      refused = 0;
      checkFlag("sleep at start", 1'b1, powerState === 2'h0);
      checkFlag("pin released", 1'b0, sdOe);
      sampleValid <= 1'b1;
      sampleData  <= 24'h800001;
      while (refused < 3 && pushed.size() < 40) begin
         @(posedge mclk);
         if (sampleReady === 1'b1) begin
            pushed.push_back(sampleData);
            sampleData <= sampleData + 24'h0F1E2D;
         end else begin
            refused++;
         end
      end
      sampleValid <= 1'b0;
      checkWord("words accepted", 24'(DEPTH + 1), 24'(pushed.size()));
   endtask

   // wake at full rate, right slot, drain the whole buffer
   task automatic wakeFullRight;
      int          n;
      logic [23:0] w;
      logic [23:0] exp;
      channelSlotSelect <= 1'b1;
      frameBits = 64;
      halfNs    = FULL_HALF;
      busRun    = 1'b1;
      waitState(mic_power_pkg::PWR_FULL, 2000);
      n = 0;
      while (sdOe !== 1'b1 && n < 5000) begin
         @(negedge mclk);
         n++;
      end
      checkFlag("wake delay", 1'b1, n >= WAKE - 1 && n < WAKE + 2200);
      if (n == 5000) tallyAndFinish;
      for (int j = 1; j <= DEPTH + 1; j++) begin
         exp = 24'h000000;
         if (j <= DEPTH) exp = {pushed[j][23:4], 4'h0};
         captureWord(1'b1, 24, w);
         checkWord("full word", exp, w);
      end
      checkFlag("room after drain", 1'b1, sampleReady);
   endtask

   task automatic lowRateLeft;
      logic [23:0] w;
      @(posedge mclk);
      channelSlotSelect <= 1'b0;
      frameBits = 48;
      halfNs    = LOW_HALF;
      waitState(mic_power_pkg::PWR_LOW, 4000);
      // empty buffer gives a silent word; also skips the cut frame
      captureWord(1'b0, 16, w);
      checkWord("idle low word", 24'h000000, w);
      @(posedge mclk);
      sampleData  <= 24'h9ABCDE;
      sampleValid <= 1'b1;
      @(posedge mclk);
      sampleValid <= 1'b0;
      captureWord(1'b0, 16, w);
      checkWord("low word", 24'h9ABC00, w);
   endtask

   task automatic gapHold;
      int gaps [2] = '{333, 1500};
      foreach (gaps[g]) begin
         halfNs = gaps[g];
         repeat (3000) @(negedge mclk);
         checkFlag("state in gap", 1'b1, powerState === 2'h1);
      end
   endtask

   // slowed clock as used to park a second device on a shared line
   task automatic slowSleep;
      int seen;
      seen   = 0;
      halfNs = 3400;
      // a frozen block must not react to the slowed clock
      @(posedge mclk);
      clkEn <= 1'b0;
      repeat (600) @(negedge mclk);
      checkFlag("state while frozen", 1'b1, powerState === 2'h1);
      @(posedge mclk);
      clkEn <= 1'b1;
      waitState(mic_power_pkg::PWR_SLEEP, 800);
      repeat (2000) begin
         @(negedge mclk);
         if (sdOe !== 1'b0 || sdOut !== 1'b0) seen++;
      end
      checkWord("driven cycles asleep", 24'h0, 24'(seen));
      busRun = 1'b0;
   endtask

   // main sequence: reset for 5 cycles, then each scenario in turn
   initial begin
      resetn            = 1'b0;
      clkEn             = 1'b1;
      channelSlotSelect = 1'b0;
      sampleData        = 24'h000000;
      sampleValid       = 1'b0;
      busRun            = 1'b0;
      halfNs            = FULL_HALF;
      frameBits         = 64;
      mismatches        = 0;
      checkCount        = 0;
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      fillWhileAsleep;
      wakeFullRight;
      lowRateLeft;
      gapHold;
      slowSleep;
      tallyAndFinish;
   end
endmodule

// file: mic_power_pkg.sv
/*
 * Shared constants and types for the bit-clock driven power-state control
 * of a serial-audio microphone slave.
 * Assumes a 50 MHz local reference clock; all counts derive from it.
 */
package mic_power_pkg;

   // ------------------------------------------------------------------
   // reference clock and band limits
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 20;
   localparam int NS_PER_KHZ_CYCLE = 1000000;
   localparam int SLEEP_FREQ_KHZ   = 200;
   localparam int LOW_FREQ_MIN_KHZ = 600;
   localparam int LOW_FREQ_MAX_KHZ = 800;
   localparam int FULL_FREQ_MIN_KHZ = 2000;
   localparam int FULL_FREQ_MAX_KHZ = 3700;
   localparam int WAKE_DELAY_US    = 6000;
   localparam int NS_PER_US        = 1000;

   // bit-clock period bounds in reference cycles: least rounds up,
   // longest rounds down
   localparam int SLEEP_CYC = NS_PER_KHZ_CYCLE
                              / (SLEEP_FREQ_KHZ * CLK_PERIOD_NS);
   localparam int LOW_MIN_CYC = (NS_PER_KHZ_CYCLE
      + LOW_FREQ_MAX_KHZ * CLK_PERIOD_NS - 1)
      / (LOW_FREQ_MAX_KHZ * CLK_PERIOD_NS);
   localparam int LOW_MAX_CYC = NS_PER_KHZ_CYCLE
                                / (LOW_FREQ_MIN_KHZ * CLK_PERIOD_NS);
   localparam int FULL_MIN_CYC = (NS_PER_KHZ_CYCLE
      + FULL_FREQ_MAX_KHZ * CLK_PERIOD_NS - 1)
      / (FULL_FREQ_MAX_KHZ * CLK_PERIOD_NS);
   localparam int FULL_MAX_CYC = NS_PER_KHZ_CYCLE
                                 / (FULL_FREQ_MIN_KHZ * CLK_PERIOD_NS);
   localparam int WAKE_CYC = WAKE_DELAY_US * NS_PER_US / CLK_PERIOD_NS;
   localparam int PERIOD_W = 9;

   // ------------------------------------------------------------------
   // serial word format
   // ------------------------------------------------------------------
   localparam int SAMPLE_BITS    = 24;
   localparam int WORD_FULL_BITS = 24;
   localparam int WORD_LOW_BITS  = 16;
   localparam int PAD_BITS       = 4;
   localparam int FIFO_DEPTH     = 16;
   localparam int BITCNT_W       = 5;

   // synchroniser lanes
   localparam int PIN_SCK  = 0;
   localparam int PIN_WS   = 1;
   localparam int PIN_CHAN = 2;
   localparam int PIN_NUM  = 3;

   // power states, gray along sleep -> low -> full
   typedef enum logic [1:0] {
      PWR_SLEEP = 2'h0,
      PWR_LOW   = 2'h1,
      PWR_FULL  = 2'h3
   } power_state_t;

endpackage

// file: mic_sample_fifo.sv
/*
 * Sample FIFO with registered read data and valid/ready on both sides.
 * Assumes DEPTH is a power of two; one extra word sits in the output
 * register, so the total capacity is DEPTH + 1.
 */
`timescale 1ns/100ps

module mic_sample_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic             clkEn,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_q;
   logic [AW-1:0]    rdPtr_q;
   logic [AW:0]      cnt_q;
   logic [AW:0]      cnt_d;
   logic             push;
   logic             load;

   // ------------------------------------------------------------------
   // handshake terms
   // ------------------------------------------------------------------
   // refill the output register whenever it is empty or being taken
   assign push  = inValid & inReady;
   assign load  = (cnt_q != '0) & (~outValid | outReady);
   assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

   // storage, no reset needed on the array
   always_ff @(posedge mclk) begin
      if (clkEn && push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   // pointers and occupancy
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         cnt_q   <= '0;
         inReady <= 1'b1;
      end else if (clkEn) begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (load) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         cnt_q   <= cnt_d;
         inReady <= cnt_d < (AW+1)'(DEPTH);   // registered back-pressure
      end
   end

   // output register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         outData  <= '0;
         outValid <= 1'b0;
      end else if (clkEn) begin
         if (load) begin
            outData  <= mem[rdPtr_q];
            outValid <= 1'b1;
         end else if (outReady) begin
            outValid <= 1'b0;
         end
      end
   end

endmodule

// file: serial_bus_host.sv
/*
 * Behavioural serial-audio bus master: makes bit clock and word select.
 * Assumes the bench sets the half period and bits per frame at will;
 * busRun low stops the bus with bit clock low and word select held at its last level.
 */
`timescale 1ns/100ps

module serial_bus_host (
   input  wire logic busRun,
   input  var int    halfNs,
   input  var int    frameBits,
   output logic      bitClk,
   output logic      wordSel
);
   int bitIdx;

   // ----------------------------------------------------------------
   // clock and frame generation
   // ----------------------------------------------------------------
   // any half period the bench sets; a frameBits change cuts the running frame
   // word select moves on the falling edge, as a real master does
   initial begin
      bitClk  = 1'b0;
      wordSel = 1'b0;
      bitIdx  = 0;
      forever begin
         if (!busRun) begin
            bitClk = 1'b0; // no free-running clock outside use
            #10;
         end else begin
            #(halfNs) bitClk = 1'b1;
            #(halfNs) bitClk = 1'b0;
            bitIdx  = (bitIdx + 1) % frameBits;
            wordSel = (bitIdx >= frameBits / 2);
         end
      end
   end
endmodule
